//--- hw/dtt_pkg.sv
package dtt_pkg;
   // Clock rate and time-base periods.
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned BASE_MS_US = 1000;
   localparam int unsigned BASE_MS_CYC = CLK_HZ / 1_000_000 * BASE_MS_US;
   localparam int unsigned MS_PER_SECONDS = 1000;
   localparam int unsigned MS_PER_TENTHS = 100;
   localparam int unsigned MS_PER_HUNDREDTHS = 10;
   localparam int unsigned MS_PER_MILLIS = 1;
   localparam int unsigned LEARN_STEP_MS = 100;
   localparam int unsigned DUR_W = 16;
   localparam int unsigned NUM_GEN = 4;
   localparam logic [15:0] DUR_RESET = 16'h0000;

   typedef struct packed {
      logic [DUR_W-1:0] onDuration;
      logic [DUR_W-1:0] offDuration;
   } dtt_setting_type;

   typedef enum logic [1:0] {
      DTT_OFF = 2'b01,
      DTT_ON = 2'b10
   } dtt_phase_type;
endpackage : dtt_pkg

//--- hw/dtt_timer.sv
`timescale 1ns/10ps
// How it works
// RQ1: Enabled generator alternates on then off phases.
// RQ2: Four generators span 1 ms to 65535 s.
// RQ3: Seconds generator counts in 1 s units.
// RQ4: Tenths generator counts in 100 ms units.
// RQ5: Hundredths generator counts in 10 ms units.
// RQ6: Learner measures start-high time into result register.
// RQ7: Millis generator counts in 1 ms units.
// RQ8: Settings are unsigned 16-bit time-base counts.
// RQ9: Start rise clears result, then counts 100 ms.
// RQ10: Start low stops counting, holds measured value.
// RQ11: Disabled generator outputs low, restarts at on.
module dtt_timer #(
   parameter int unsigned MS_CYCLES = dtt_pkg::BASE_MS_CYC
) (
   // Clock, reset and freeze.
   input wire logic mclk,
   input wire logic rst,
   input wire logic clkEn,
   // Pulse generators: seconds, tenths, hundredths, millis.
   input wire logic [dtt_pkg::NUM_GEN-1:0] genEnable,
   input dtt_pkg::dtt_setting_type genSetting [dtt_pkg::NUM_GEN],
   output logic [dtt_pkg::NUM_GEN-1:0] pulseOutputTarget,
   // Duration learner.
   input wire logic learnStart,
   output logic [dtt_pkg::DUR_W-1:0] learnResult,
   output logic learnBusy
);
   import dtt_pkg::*;

   localparam int unsigned MS_MULT [NUM_GEN] = '{MS_PER_SECONDS, MS_PER_TENTHS,
                                                 MS_PER_HUNDREDTHS, MS_PER_MILLIS};

   // The enable and start inputs pass a two-stage synchroniser.
   logic [NUM_GEN:0] syncA_reg;
   logic [NUM_GEN:0] syncB_reg;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         syncA_reg <= '0;
         syncB_reg <= '0;
      end else if (clkEn) begin
         syncA_reg <= {learnStart, genEnable};
         syncB_reg <= syncA_reg;
      end
   end

   // Shared millisecond tick.
   logic [31:0] msCnt_reg;
   logic msTick;
   assign msTick = (msCnt_reg == 32'(MS_CYCLES - 1));
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         msCnt_reg <= '0;
      end else if (clkEn) begin
         msCnt_reg <= msTick ? 32'h00000000 : msCnt_reg + 32'h00000001;
      end
   end

   // Every generator owns a divider from the shared millisecond tick down to its
   // own base, an elapsed counter for the phase in progress, the phase and the
   // registered output. The millisecond counter runs free, so the very first base
   // unit after an enable may be short; later phases are exact.
   genvar g;
   for (g = 0; g < NUM_GEN; g++) begin : gen_pulse
      // Each generator divides the ms tick to its own base. [RQ2] [RQ3] [RQ4] [RQ5] [RQ7]
      localparam logic [9:0] BASE_LAST = 10'(MS_MULT[g] - 1);

      logic en;
      logic [9:0] baseCnt_reg;
      logic baseTick;
      logic [DUR_W-1:0] elapsed_reg;
      logic [DUR_W-1:0] target;
      logic phaseDone;
      logic onNonZero;
      dtt_phase_type phase_reg;
      dtt_phase_type phase_next;
      logic out_reg;
      logic out_next;

      assign en = syncB_reg[g];
      assign baseTick = msTick && (baseCnt_reg == BASE_LAST);
      // Settings are read live as plain 16-bit counts of the base. [RQ8]
      assign target = (phase_reg == DTT_ON) ? genSetting[g].onDuration : genSetting[g].offDuration;
      assign phaseDone = (elapsed_reg >= target);
      assign onNonZero = (genSetting[g].onDuration != DUR_RESET);

      // Base divider; held at zero while the generator is idle. [RQ11]
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            baseCnt_reg <= '0;
         end else if (clkEn) begin
            if (!en) begin
               baseCnt_reg <= '0;
            end else if (baseTick) begin
               baseCnt_reg <= '0;
            end else if (msTick) begin
               baseCnt_reg <= baseCnt_reg + 10'h001;
            end
         end
      end

      // Phase sequencing: a finished phase hands over to the other one. [RQ1]
      always_comb begin
         phase_next = phase_reg;
         if (!en) begin
            // An idle generator waits in the on phase, so enabling starts there. [RQ11]
            phase_next = DTT_ON;
         end else if (phaseDone) begin
            case (phase_reg)
               DTT_ON: begin
                  phase_next = DTT_OFF;
               end
               DTT_OFF: begin
                  phase_next = DTT_ON;
               end
               default: begin
                  phase_next = DTT_ON;
               end
            endcase
         end
      end

      // The phase register; reset leaves it in the on phase.
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            phase_reg <= DTT_ON;
         end else if (clkEn) begin
            phase_reg <= phase_next;
         end
      end

      // Elapsed base units of the current phase. A tick that falls on the change of
      // phase already belongs to the new phase, so no unit is lost.
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            elapsed_reg <= DUR_RESET;
         end else if (clkEn) begin
            if (!en) begin
               elapsed_reg <= DUR_RESET; // [RQ11]
            end else if (phaseDone) begin
               elapsed_reg <= baseTick ? 16'h0001 : DUR_RESET;
            end else if (baseTick) begin
               elapsed_reg <= elapsed_reg + 16'h0001;
            end
         end
      end

      // The output follows the next phase. A zero on time keeps it low, so a skipped
      // on phase never shows as a one-cycle pulse.
      always_comb begin
         out_next = 1'b0;
         if (en && phase_next == DTT_ON) begin
            out_next = onNonZero; // [RQ1]
         end
      end

      // Registered output, so the pin never glitches.
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            out_reg <= 1'b0;
         end else if (clkEn) begin
            out_reg <= out_next; // [RQ11]
         end
      end

      assign pulseOutputTarget[g] = out_reg;
   end

   // Duration learner in 100 ms steps. The previous start level doubles as the
   // busy flag, so busy trails the synchronised start by one cycle.
   logic learnIn;
   logic learnPrev_reg;
   logic learnRise;
   logic learnTick;
   logic [6:0] stepCnt_reg;
   logic stepDone;
   logic resultFull;

   assign learnIn = syncB_reg[NUM_GEN];
   // A new measurement begins in the first cycle the synchronised start is high.
   assign learnRise = learnIn && !learnPrev_reg;
   assign learnTick = learnIn && msTick;
   assign stepDone = learnTick && (stepCnt_reg == 7'(LEARN_STEP_MS - 1));
   assign resultFull = (learnResult == 16'hFFFF);
   assign learnBusy = learnPrev_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         learnPrev_reg <= 1'b0;
      end else if (clkEn) begin
         learnPrev_reg <= learnIn;
      end
   end

   // Milliseconds within the current step; each new measurement restarts the step.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stepCnt_reg <= '0;
      end else if (clkEn) begin
         if (learnRise || stepDone) begin
            stepCnt_reg <= '0;
         end else if (learnTick) begin
            stepCnt_reg <= stepCnt_reg + 7'h01;
         end
      end
   end

   // The result clears on a rising start and then advances once per step. It
   // saturates instead of wrapping, so an overlong press reads as the longest time.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         learnResult <= DUR_RESET;
      end else if (clkEn) begin
         if (learnRise) begin
            learnResult <= DUR_RESET; // [RQ9]
         end else if (stepDone && !resultFull) begin
            learnResult <= learnResult + 16'h0001; // [RQ6] [RQ9]
         end
         // While start is low the result simply holds. [RQ10]
      end
   end
endmodule : dtt_timer

//--- verif/dtt_timer_monitor.sv
`timescale 1ns/10ps
module dtt_timer_monitor (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Watched ports.
   input wire logic [dtt_pkg::NUM_GEN-1:0] genEnable,
   input wire logic [dtt_pkg::NUM_GEN-1:0] pulseOutputTarget,
   input wire logic learnStart,
   input wire logic [dtt_pkg::DUR_W-1:0] learnResult,
   input wire logic learnBusy
);
   import dtt_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sec_off_a: assert property (!genEnable[0] [*4] |-> !pulseOutputTarget[0]) else $error("sec high");
   tenth_off_a: assert property (!genEnable[1] [*4] |-> !pulseOutputTarget[1]) else $error("tenth high");
   hund_off_a: assert property (!genEnable[2] [*4] |-> !pulseOutputTarget[2]) else $error("hund high");
   milli_off_a: assert property (!genEnable[3] [*4] |-> !pulseOutputTarget[3]) else $error("milli high");
   learn_hold_a: assert property (!learnStart [*5] |-> $stable(learnResult)) else $error("count moved");
   learn_step_a: assert property ($changed(learnResult) |->
      learnResult == $past(learnResult) + 16'h0001 || learnResult == 16'h0000) else $error("bad step");
   learn_clear_a: assert property ($rose(learnStart) |-> ##[2:5] learnResult == 16'h0000) else $error("no clear");
   learn_busy_a: assert property (learnStart [*4] |-> learnBusy) else $error("not busy");
endmodule : dtt_timer_monitor

bind dtt_timer dtt_timer_monitor i_dtt_timer_monitor (.mclk(mclk), .rst(rst), .genEnable(genEnable),
   .pulseOutputTarget(pulseOutputTarget), .learnStart(learnStart), .learnResult(learnResult),
   .learnBusy(learnBusy));

//--- verif/dtt_timer_tb_top.sv
`timescale 1ns/10ps
module dtt_timer_tb_top;
   import dtt_pkg::*;
   localparam int unsigned MSC = 10;
   logic mclk, rst, clkEn, learnStart, learnBusy;
   logic [NUM_GEN-1:0] genEnable, pulseOutputTarget;
   dtt_setting_type genSetting [NUM_GEN];
   logic [DUR_W-1:0] learnResult;
   int err_total = 0;
   int check_count = 0;
   dtt_timer #(.MS_CYCLES(MSC)) i_dtt_timer (.mclk(mclk), .rst(rst), .clkEn(clkEn), .genEnable(genEnable),
      .genSetting(genSetting), .pulseOutputTarget(pulseOutputTarget), .learnStart(learnStart),
      .learnResult(learnResult), .learnBusy(learnBusy));
   task summarize;
      if (err_total == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", name, e, g);
      end
   endtask : chk
   // Counts cycles until the output shows the wanted level.
   task waitv(input int k, input logic v, output int n);
      n = 0;
      while (pulseOutputTarget[k] !== v && n < 30000) begin
         @(negedge mclk);
         n++;
      end
   endtask : waitv
   // The first period is skipped because its first base unit may be short.
   task gen_check(input int k, input logic [15:0] onU, input logic [15:0] offU, input int base);
      int n, h, l;
      @(posedge mclk);
      genSetting[k] <= {onU, offU};
      genEnable[k] <= 1'b1;
      repeat (4) @(negedge mclk);
      chk("start level", 32'h1, pulseOutputTarget[k]);
      waitv(k, 1'b1, n);
      waitv(k, 1'b0, n);
      waitv(k, 1'b1, n);
      waitv(k, 1'b0, h);
      waitv(k, 1'b1, l);
      chk("on cycles", onU * base * MSC, h);
      chk("off cycles", offU * base * MSC, l);
      @(posedge mclk);
      genEnable[k] <= 1'b0;
      repeat (4) @(negedge mclk);
      chk("disabled output", 32'h0, pulseOutputTarget[k]);
   endtask : gen_check
   // One count is 100 ms, that is 100 * MSC cycles.
   task learn(input int hold, input logic [15:0] expv);
      @(posedge mclk);
      learnStart <= 1'b1;
      repeat (hold) @(posedge mclk);
      learnStart <= 1'b0;
      repeat (2000) @(negedge mclk);
      chk("learned count", expv, learnResult);
   endtask : learn
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      repeat (90000) @(posedge mclk);
      err_total++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      clkEn = 1'b1;
      learnStart = 1'b0;
      genEnable = '0;
      foreach (genSetting[i]) genSetting[i] = '0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      gen_check(3, 16'h0005, 16'h0003, 1);
      gen_check(2, 16'h0003, 16'h0002, 10);
      gen_check(1, 16'h0002, 16'h0001, 100);
      gen_check(0, 16'h0001, 16'h0001, 1000);
      learn(3500, 16'h0003);
      learn(1500, 16'h0001);
      summarize();
   end
endmodule : dtt_timer_tb_top
